// ### frmc_pkg.sv
`default_nettype none
package frmc_pkg;
  localparam int DW = 36;
  localparam int AW = 9;
  localparam int PW = 10;
  localparam logic [PW-1:0] DEPTH = 10'h200;
  localparam logic [AW-1:0] OFFS_PRESET = 9'h008;
  // Sync bundles: clock, select, direction, enable, mail select, ...
  localparam int A_SYNC_W = 41;
  localparam int B_SYNC_W = 43;
  // APB map
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] STAT_OFS = 12'h004;
  localparam logic [11:0] OFFS_OFS = 12'h008;
  localparam int CTRL_FALL = 0;
  localparam int CTRL_PROG = 1;
  localparam int CTRL_FRST = 2;
  localparam logic [1:0] CTRL_RESET = 2'h1;
  localparam int ST_OR = 0;
  localparam int ST_AL_EMPTY = 1;
  localparam int ST_IN_RDY = 2;
  localparam int ST_AL_FULL = 3;
  localparam int ST_MB1 = 4;
  localparam int ST_MB2 = 5;
  localparam int ST_RETX = 6;
  localparam int ST_PROG = 7;
  localparam int OFFS_X_LSB = 0;
  localparam int OFFS_Y_LSB = 16;
  typedef enum logic [1:0] {FRMC_PROG_IDLE, FRMC_PROG_X, FRMC_PROG_Y}
    frmc_prog_t;
endpackage : frmc_pkg
`default_nettype wire

// ### frmc_sub.sv
`timescale 1ns/100ps
`default_nettype none
// Two-flop synchroniser for a bundle of pin inputs
module frmc_sync #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q <= '0;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : frmc_sync

// One mailbox register with its active-low full flag
module frmc_mailbox (
  input wire logic clk,
  input wire logic rst,
  input wire logic wr_ev,
  input wire logic rd_ev,
  input wire logic [frmc_pkg::DW-1:0] wdata,
  output logic [frmc_pkg::DW-1:0] data_q,
  output logic full_n_q
);
  logic wr_ok;

  assign wr_ok = wr_ev & full_n_q;

  always_ff @(posedge clk) begin
    if (rst) begin
      data_q <= '0;
    end else if (wr_ok) begin
      data_q <= wdata;
    end
  end

  // A write in the same cycle as a read wins, so new mail is never hidden
  always_ff @(posedge clk) begin
    if (rst) begin
      full_n_q <= 1'b1;
    end else if (wr_ok) begin
      full_n_q <= 1'b0;
    end else if (rd_ev) begin
      full_n_q <= 1'b1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  mb_reset_full_a: assert property ($fell(rst) |-> full_n_q)
    else $error("mailbox flag not high after reset");
  mb_write_a: assert property (wr_ev && full_n_q |=>
    !full_n_q && data_q == $past(wdata))
    else $error("accepted mail write not stored");
  mb_hold_a: assert property (!(wr_ev && full_n_q) |=> $stable(data_q))
    else $error("mailbox changed without accepted write");
  mb_read_a: assert property (rd_ev && !wr_ev |=> full_n_q)
    else $error("mailbox read did not set flag");
endmodule : frmc_mailbox
`default_nettype wire

// ### frmc_top.sv
// What this block does
// - Fill-level flags count memory words only, not the output register word.
// - A word moved to the output register frees its memory location.
// - Fall-through mode moves the first word to output without a read.
// - Read-from-mark in retransmit mode reloads read pointer; output_ready updates at once.
// - Retransmit leaving almost-empty range raises almost_empty_flag within two B edges.
// - Leaving retransmit switches input_ready/almost_full pointer from shadow to current.
// - Flags rising after retransmit exit wait at least two A sync cycles.
// - Two 36-bit mailboxes, chosen per transfer by the mail select inputs.
// - Selected port A write with mail select high stores into mail1.
// - Selected port B write with mail select high stores into mail2.
// - Writing a mailbox drives its full flag low.
// - Writes to a mailbox are discarded while its full flag is low.
// - Port B drives output register, or mail1 when its mail select is high.
// - Port A always drives mail2 contents when its outputs are enabled.
// - Selected port B mail read sets mail1_full_flag high.
// - Selected port A mail read sets mail2_full_flag high.
// - Reading a mailbox leaves contents; only accepted writes change them.
// - During offset programming FIFO writes are ignored until input_ready is high.
// - A FIFO reset loads both offsets with the preset value eight.
// - Write into empty FIFO shows output_ready and data within three B cycles.
// - A read freeing a location raises input_ready on the third port A edge after it.
// - Enter retransmit on B edge with mode select and output_ready high.
// - In retransmit the shadow pointer stays fixed and guards against overwrites.
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/100ps
`default_nettype none
module frmc_top (
  input wire logic clk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic port_a_clock,
  input wire logic port_a_chip_select_n,
  input wire logic port_a_write_not_read,
  input wire logic port_a_enable,
  input wire logic port_a_mail_select,
  input wire logic [35:0] port_a_data_in,
  output logic [35:0] port_a_data_out,
  output logic port_a_data_oe,
  input wire logic port_b_clock,
  input wire logic port_b_chip_select_n,
  input wire logic port_b_write_not_read,
  input wire logic port_b_enable,
  input wire logic port_b_mail_select,
  input wire logic retransmit_mode_select,
  input wire logic read_from_mark,
  input wire logic [35:0] port_b_data_in,
  output logic [35:0] port_b_data_out,
  output logic port_b_data_oe,
  output logic output_ready,
  output logic almost_empty_flag,
  output logic input_ready,
  output logic almost_full_flag,
  output logic mail1_full_flag,
  output logic mail2_full_flag
);
  localparam int DW = frmc_pkg::DW;
  localparam int AW = frmc_pkg::AW;
  localparam int PW = frmc_pkg::PW;

  logic [frmc_pkg::A_SYNC_W-1:0] a_q;
  logic [frmc_pkg::B_SYNC_W-1:0] b_q;
  logic a_clk_d_r, b_clk_d_r, a_rise, b_rise;
  logic a_cs_n, a_wnr, a_en, a_mba, b_cs_n, b_wnr, b_en, b_mbb;
  logic b_rt_sel, b_rt_mark;
  logic [DW-1:0] a_data, b_data, mail1_q, mail2_q;
  logic a_sel_wr, a_sel_rd, b_sel_wr, b_sel_rd;
  logic fifo_wr, fifo_wr_ok, fifo_rd, rtx_ev, take;
  logic mail1_full_n, mail2_full_n;

  logic [DW-1:0] mem [0:(1<<AW)-1];
  logic [PW-1:0] wptr_r, wptr_nxt, wsync1_r, wsync2_r;
  logic [PW-1:0] rptr_r, rptr_nxt, shadow_r, rsync1_r, rsync2_r, rflag_ptr;
  logic [PW-1:0] count_b, count_b_nxt, count_a_nxt;
  logic [AW-1:0] rd_addr, x_r, y_r;
  logic [DW-1:0] out_reg_r;
  logic rt_mode_r, soft_rst_r, fall_thru_r, prog_en_r;
  frmc_pkg::frmc_prog_t prog_st_r;

  // Port pins cross into clk before anything looks at them
  frmc_sync #(.W(frmc_pkg::A_SYNC_W)) u_sync_a (
    .clk(clk),
    .rst(rst),
    .d({port_a_clock, port_a_chip_select_n, port_a_write_not_read,
        port_a_enable, port_a_mail_select, port_a_data_in}),
    .q(a_q)
  );
  frmc_sync #(.W(frmc_pkg::B_SYNC_W)) u_sync_b (
    .clk(clk),
    .rst(rst),
    .d({port_b_clock, port_b_chip_select_n, port_b_write_not_read,
        port_b_enable, port_b_mail_select, retransmit_mode_select,
        read_from_mark, port_b_data_in}),
    .q(b_q)
  );

  assign {a_cs_n, a_wnr, a_en, a_mba, a_data} = a_q[39:0];
  assign {b_cs_n, b_wnr, b_en, b_mbb, b_rt_sel, b_rt_mark, b_data} = b_q[41:0];

  always_ff @(posedge clk) begin
    if (rst) begin
      a_clk_d_r <= 1'b0;
      b_clk_d_r <= 1'b0;
    end else begin
      a_clk_d_r <= a_q[40];
      b_clk_d_r <= b_q[42];
    end
  end

  assign a_rise = a_q[40] & ~a_clk_d_r;
  assign b_rise = b_q[42] & ~b_clk_d_r;
  assign a_sel_wr = a_rise & ~a_cs_n & a_wnr & a_en;
  assign a_sel_rd = a_rise & ~a_cs_n & ~a_wnr & a_en;
  assign b_sel_wr = b_rise & ~b_cs_n & ~b_wnr & b_en;
  assign b_sel_rd = b_rise & ~b_cs_n & b_wnr & b_en;

  // Mailboxes, one per direction
  frmc_mailbox u_mail1 (
    .clk(clk),
    .rst(rst),
    .wr_ev(a_sel_wr & a_mba),
    .rd_ev(b_sel_rd & b_mbb),
    .wdata(a_data),
    .data_q(mail1_q),
    .full_n_q(mail1_full_n)
  );
  frmc_mailbox u_mail2 (
    .clk(clk),
    .rst(rst),
    .wr_ev(b_sel_wr & b_mbb),
    .rd_ev(a_sel_rd & a_mba),
    .wdata(b_data),
    .data_q(mail2_q),
    .full_n_q(mail2_full_n)
  );

  // Offset programming: first FIFO-write word loads X, the next loads Y
  assign fifo_wr = a_sel_wr & ~a_mba;
  assign fifo_wr_ok = fifo_wr & input_ready &
                      (prog_st_r == frmc_pkg::FRMC_PROG_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      prog_st_r <= frmc_pkg::FRMC_PROG_IDLE;
      x_r <= frmc_pkg::OFFS_PRESET;
      y_r <= frmc_pkg::OFFS_PRESET;
    end else if (soft_rst_r) begin
      x_r <= frmc_pkg::OFFS_PRESET;
      y_r <= frmc_pkg::OFFS_PRESET;
      prog_st_r <= prog_en_r ? frmc_pkg::FRMC_PROG_X
                             : frmc_pkg::FRMC_PROG_IDLE;
    end else if (fifo_wr) begin
      case (prog_st_r)
        frmc_pkg::FRMC_PROG_X: begin
          x_r <= a_data[AW-1:0];
          prog_st_r <= frmc_pkg::FRMC_PROG_Y;
        end
        frmc_pkg::FRMC_PROG_Y: begin
          y_r <= a_data[AW-1:0];
          prog_st_r <= frmc_pkg::FRMC_PROG_IDLE;
        end
        default: prog_st_r <= frmc_pkg::FRMC_PROG_IDLE;
      endcase
    end
  end

  // Write side, paced by port A edges
  assign wptr_nxt = fifo_wr_ok ? wptr_r + 10'h001 : wptr_r;
  // Shadow pointer guards retransmit data; current pointer once out
  assign rflag_ptr = rt_mode_r ? shadow_r : rptr_r;
  // Uses the old synced read pointer: pessimistic, never overflows
  assign count_a_nxt = wptr_nxt - rsync2_r;

  always_ff @(posedge clk) begin
    if (fifo_wr_ok) begin
      mem[wptr_r[AW-1:0]] <= a_data;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || soft_rst_r) begin
      wptr_r <= '0;
      rsync1_r <= '0;
      rsync2_r <= '0;
      input_ready <= 1'b0;
      almost_full_flag <= 1'b1;
    end else if (a_rise) begin
      wptr_r <= wptr_nxt;
      rsync1_r <= rflag_ptr;
      rsync2_r <= rsync1_r;
      input_ready <= (prog_st_r == frmc_pkg::FRMC_PROG_IDLE) &&
                     (count_a_nxt != frmc_pkg::DEPTH);
      almost_full_flag <= count_a_nxt <
                          (frmc_pkg::DEPTH - {1'b0, y_r});
    end
  end

  // Read side, paced by port B edges
  assign count_b = wsync2_r - rptr_r;
  assign fifo_rd = b_sel_rd & ~b_mbb & output_ready;
  assign rtx_ev = b_rise & rt_mode_r & b_rt_mark;
  assign take = fall_thru_r ? ((~output_ready | fifo_rd) & (count_b != '0))
                       : (fifo_rd & (count_b != '0));
  assign rptr_nxt = rtx_ev ? shadow_r + 10'h001 :
                    (take ? rptr_r + 10'h001 : rptr_r);
  assign rd_addr = rtx_ev ? shadow_r[AW-1:0] : rptr_r[AW-1:0];
  assign count_b_nxt = wsync2_r - rptr_nxt;

  always_ff @(posedge clk) begin
    if (rst || soft_rst_r) begin
      wsync1_r <= '0;
      wsync2_r <= '0;
      rptr_r <= '0;
      out_reg_r <= '0;
      output_ready <= 1'b0;
      almost_empty_flag <= 1'b0;
    end else if (b_rise) begin
      wsync1_r <= wptr_r;
      wsync2_r <= wsync1_r;
      rptr_r <= rptr_nxt;
      if (rtx_ev || take) begin
        out_reg_r <= mem[rd_addr];
      end
      if (rtx_ev) begin
        output_ready <= 1'b1;
      end else if (fall_thru_r) begin
        output_ready <= take | (output_ready & ~fifo_rd);
      end else begin
        output_ready <= count_b_nxt != '0;
      end
      almost_empty_flag <= count_b_nxt > {1'b0, x_r};
    end
  end

  // Retransmit mode: shadow marks the word now in the output register
  always_ff @(posedge clk) begin
    if (rst || soft_rst_r) begin
      rt_mode_r <= 1'b0;
      shadow_r <= '0;
    end else if (b_rise) begin
      if (!rt_mode_r && b_rt_sel && output_ready) begin
        rt_mode_r <= 1'b1;
        shadow_r <= rptr_r - 10'h001;
      end else if (rt_mode_r && !b_rt_sel) begin
        rt_mode_r <= 1'b0;
      end
    end
  end

  // Pin drivers, all registered
  always_ff @(posedge clk) begin
    if (rst) begin
      port_a_data_out <= '0;
      port_a_data_oe <= 1'b0;
      port_b_data_out <= '0;
      port_b_data_oe <= 1'b0;
      mail1_full_flag <= 1'b1;
      mail2_full_flag <= 1'b1;
    end else begin
      port_a_data_out <= mail2_q;
      port_a_data_oe <= ~a_cs_n & ~a_wnr;
      port_b_data_out <= b_mbb ? mail1_q : out_reg_r;
      port_b_data_oe <= ~b_cs_n & b_wnr;
      mail1_full_flag <= mail1_full_n;
      mail2_full_flag <= mail2_full_n;
    end
  end

  // APB slave, one wait state per transfer
  logic apb_access, apb_done;
  logic [31:0] rd_word;
  logic bad_addr;

  assign apb_access = psel & penable & ~pready;
  assign apb_done = psel & penable & pready;

  always_comb begin
    rd_word = 32'h0000_0000;
    bad_addr = 1'b0;
    if (paddr == frmc_pkg::CTRL_OFS) begin
      rd_word[frmc_pkg::CTRL_FALL] = fall_thru_r;
      rd_word[frmc_pkg::CTRL_PROG] = prog_en_r;
    end else if (paddr == frmc_pkg::STAT_OFS) begin
      rd_word[frmc_pkg::ST_OR] = output_ready;
      rd_word[frmc_pkg::ST_AL_EMPTY] = almost_empty_flag;
      rd_word[frmc_pkg::ST_IN_RDY] = input_ready;
      rd_word[frmc_pkg::ST_AL_FULL] = almost_full_flag;
      rd_word[frmc_pkg::ST_MB1] = mail1_full_flag;
      rd_word[frmc_pkg::ST_MB2] = mail2_full_flag;
      rd_word[frmc_pkg::ST_RETX] = rt_mode_r;
      rd_word[frmc_pkg::ST_PROG] = prog_st_r != frmc_pkg::FRMC_PROG_IDLE;
    end else if (paddr == frmc_pkg::OFFS_OFS) begin
      rd_word[frmc_pkg::OFFS_X_LSB +: AW] = x_r;
      rd_word[frmc_pkg::OFFS_Y_LSB +: AW] = y_r;
    end else begin
      bad_addr = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_access;
      pslverr <= apb_access & bad_addr;
      prdata <= (apb_access && !pwrite) ? rd_word : 32'h0000_0000;
    end
  end

  // Writing the reset bit starts a FIFO reset; it clears itself
  always_ff @(posedge clk) begin
    if (rst) begin
      fall_thru_r <= frmc_pkg::CTRL_RESET[0];
      prog_en_r <= frmc_pkg::CTRL_RESET[1];
      soft_rst_r <= 1'b0;
    end else begin
      soft_rst_r <= 1'b0;
      if (apb_done && pwrite && paddr == frmc_pkg::CTRL_OFS) begin
        fall_thru_r <= pwdata[frmc_pkg::CTRL_FALL];
        prog_en_r <= pwdata[frmc_pkg::CTRL_PROG];
        soft_rst_r <= pwdata[frmc_pkg::CTRL_FRST];
      end
    end
  end

  // Helper: port B edges seen since the last retransmit
  logic [1:0] rtx_edges_r;
  always_ff @(posedge clk) begin
    if (rst) begin
      rtx_edges_r <= 2'h3;
    end else if (rtx_ev) begin
      rtx_edges_r <= 2'h0;
    end else if (b_rise && rtx_edges_r != 2'h3) begin
      rtx_edges_r <= rtx_edges_r + 2'h1;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_frst;
    soft_rst_r ##1 !soft_rst_r;
  endsequence
  offs_preset_a: assert property (s_frst |-> x_r == frmc_pkg::OFFS_PRESET &&
    y_r == frmc_pkg::OFFS_PRESET)
    else $error("offsets not preset by fifo reset");
  prog_block_a: assert property (fifo_wr &&
    prog_st_r != frmc_pkg::FRMC_PROG_IDLE && !soft_rst_r |=> $stable(wptr_r))
    else $error("fifo write taken during offset programming");
  rtx_reload_a: assert property (rtx_ev && !soft_rst_r |=>
    rptr_r == $past(shadow_r) + 10'h001 && output_ready)
    else $error("retransmit did not reload read pointer");
  shadow_hold_a: assert property (rt_mode_r && !soft_rst_r &&
    !(b_rise && !b_rt_sel) |=> rt_mode_r && $stable(shadow_r))
    else $error("shadow pointer moved in retransmit");
  fall_through_a: assert property (b_rise && fall_thru_r && !soft_rst_r &&
    !output_ready && count_b != '0 |=> output_ready && rptr_r == $past(rptr_r) + 10'h001)
    else $error("first word did not fall through");
  empty_retx_a: assert property (rtx_edges_r == 2'h2 && count_b > {1'b0, x_r}
    |-> almost_empty_flag)
    else $error("almost empty late after retransmit");
  in_ptr_sync_a: assert property (a_rise && !soft_rst_r |=> rsync1_r ==
    $past(rflag_ptr) && rsync2_r == $past(rsync1_r))
    else $error("write side flag pointer not synced in two stages");
  b_mux_a: assert property (b_mbb ##1 1'b1 |-> port_b_data_out == $past(mail1_q))
    else $error("port b mail data not driven");
  a_mux_a: assert property (##1 port_a_data_out == $past(mail2_q))
    else $error("port a mail2 data not driven");
endmodule : frmc_top
`default_nettype wire

// ### frmc_port_host.sv
`timescale 1ns/100ps
`default_nettype none
// Hosts on ports A and B; port clocks run free, as on the real part
module frmc_port_host (
  input wire logic clk,
  output logic port_a_clock,
  output logic port_a_chip_select_n,
  output logic port_a_write_not_read,
  output logic port_a_enable,
  output logic port_a_mail_select,
  output logic [35:0] port_a_data_in,
  output logic port_b_clock,
  output logic port_b_chip_select_n,
  output logic port_b_write_not_read,
  output logic port_b_enable,
  output logic port_b_mail_select,
  output logic retransmit_mode_select,
  output logic read_from_mark,
  output logic [35:0] port_b_data_in
);
  int ca = 0;
  int cb = 0;
  initial begin
    port_a_clock = 1'b0;
    port_b_clock = 1'b0;
    {port_a_chip_select_n, port_a_write_not_read} = 2'h2;
    {port_a_enable, port_a_mail_select} = 2'h0;
    {port_b_chip_select_n, port_b_write_not_read} = 2'h2;
    {port_b_enable, port_b_mail_select} = 2'h0;
    {retransmit_mode_select, read_from_mark} = 2'h0;
    port_a_data_in = 36'h0;
    port_b_data_in = 36'h0;
  end
  // Phases of 4 and 5 system clocks keep every edge visible to the block
  always @(posedge clk) begin
    ca <= (ca == 3) ? 0 : ca + 1;
    cb <= (cb == 4) ? 0 : cb + 1;
    if (ca == 3) port_a_clock <= ~port_a_clock;
    if (cb == 4) port_b_clock <= ~port_b_clock;
  end
  // Controls change at the falling edge, so they are settled at the rise
  task automatic a_op(input logic [3:0] c, input logic [35:0] d);
    @(negedge port_a_clock);
    {port_a_chip_select_n, port_a_write_not_read} <= c[3:2];
    {port_a_enable, port_a_mail_select} <= c[1:0];
    port_a_data_in <= d;
    @(negedge port_a_clock);
    port_a_chip_select_n <= 1'b1;
    port_a_enable <= 1'b0;
    port_a_data_in <= ~d;
    repeat (2) @(posedge clk);
  endtask : a_op
  // c is {mode select, read from mark, select_n, write_not_read, en, mail}
  task automatic b_op(input logic [5:0] c, input logic [35:0] d);
    @(negedge port_b_clock);
    {retransmit_mode_select, read_from_mark} <= c[5:4];
    {port_b_chip_select_n, port_b_write_not_read} <= c[3:2];
    {port_b_enable, port_b_mail_select} <= c[1:0];
    port_b_data_in <= d;
    @(negedge port_b_clock);
    read_from_mark <= 1'b0;
    {port_b_chip_select_n, port_b_write_not_read} <= 2'h2;
    port_b_enable <= 1'b0;
    port_b_data_in <= ~d;
    repeat (2) @(posedge clk);
  endtask : b_op
endmodule : frmc_port_host
`default_nettype wire

// ### fifo_retransmit_mailbox_ctrl_test.sv
`timescale 1ns/100ps
`default_nettype none
module fifo_retransmit_mailbox_ctrl_test;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, er;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic a_clk, a_cs_n, a_wnr, a_en, a_mail, a_oe;
  logic b_clk, b_cs_n, b_wnr, b_en, b_mail, b_oe, rt_sel, rt_mark;
  logic [35:0] a_din, a_dout, b_din, b_dout, m;
  logic o_rdy, al_empty, i_rdy, al_full, mb1, mb2;
  logic [35:0] w [12];
  int fails = 0;
  int n_checks = 0;

  frmc_top i_frmc_top (.clk(clk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .port_a_clock(a_clk), .port_a_chip_select_n(a_cs_n),
    .port_a_write_not_read(a_wnr), .port_a_enable(a_en),
    .port_a_mail_select(a_mail), .port_a_data_in(a_din),
    .port_a_data_out(a_dout), .port_a_data_oe(a_oe),
    .port_b_clock(b_clk), .port_b_chip_select_n(b_cs_n),
    .port_b_write_not_read(b_wnr), .port_b_enable(b_en),
    .port_b_mail_select(b_mail), .retransmit_mode_select(rt_sel),
    .read_from_mark(rt_mark), .port_b_data_in(b_din),
    .port_b_data_out(b_dout), .port_b_data_oe(b_oe),
    .output_ready(o_rdy), .almost_empty_flag(al_empty), .input_ready(i_rdy),
    .almost_full_flag(al_full), .mail1_full_flag(mb1), .mail2_full_flag(mb2));
  frmc_port_host i_frmc_port_host (.clk(clk), .port_a_clock(a_clk),
    .port_a_chip_select_n(a_cs_n), .port_a_write_not_read(a_wnr),
    .port_a_enable(a_en), .port_a_mail_select(a_mail),
    .port_a_data_in(a_din), .port_b_clock(b_clk),
    .port_b_chip_select_n(b_cs_n), .port_b_write_not_read(b_wnr),
    .port_b_enable(b_en), .port_b_mail_select(b_mail),
    .retransmit_mode_select(rt_sel), .read_from_mark(rt_mark),
    .port_b_data_in(b_din));

  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic end_of_test();
    if (fails == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fails++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1 && ++n < 50);
    if (n >= 50) fails++;
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // Flags settle some port clock edges after the event, plus the sync path
  task automatic bw(input int n);
    repeat (n) @(posedge b_clk);
    repeat (6) @(posedge clk);
  endtask : bw

  function automatic logic empty_exp(input int mem);
    return mem > int'(frmc_pkg::OFFS_PRESET);
  endfunction : empty_exp

  function automatic logic [35:0] rnd36();
    logic [63:0] v;
    v = {$urandom(), $urandom()};
    return v[35:0];
  endfunction : rnd36

  initial begin
    #(50 * 40000);
    fails++;
    end_of_test();
  end

  initial begin
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    void'($urandom(28318));
    bw(3);
    chk(36'({a_oe, b_oe}), 36'h0);
    apb(1'b0, frmc_pkg::CTRL_OFS, 32'h0);
    chk({4'h0, rd}, 36'h1);
    apb(1'b0, frmc_pkg::OFFS_OFS, 32'h0);
    chk({4'h0, rd}, 36'h000080008);
    apb(1'b1, frmc_pkg::STAT_OFS, 32'hff);
    apb(1'b0, frmc_pkg::STAT_OFS, 32'h0);
    chk({28'h0, rd[7:0]}, 36'h3c);
    apb(1'b0, 12'h00c, 32'h0);
    chk({3'h0, er, rd}, 36'h100000000);
    m = rnd36();
    i_frmc_port_host.a_op(4'b0111, m);
    chk(36'(mb1), 36'h0);
    i_frmc_port_host.a_op(4'b0111, ~m);
    repeat (2) begin
      i_frmc_port_host.b_op(6'b000111, 36'h0);
      chk(b_dout, m);
      chk(36'(mb1), 36'h1);
    end
    m = rnd36();
    i_frmc_port_host.b_op(6'b000011, m);
    chk(36'(mb2), 36'h0);
    i_frmc_port_host.a_op(4'b0011, 36'h0);
    chk(a_dout, m);
    chk(36'(mb2), 36'h1);
    i_frmc_port_host.b_op(6'b000100, 36'h0);
    foreach (w[i]) w[i] = rnd36();
    i_frmc_port_host.a_op(4'b0110, w[0]);
    bw(4);
    chk(36'(o_rdy), 36'h1);
    chk(b_dout, w[0]);
    for (int i = 1; i < 12; i++) begin
      i_frmc_port_host.a_op(4'b0110, w[i]);
      if (i == 8) bw(4);
      if (i == 8) chk(36'(al_empty), 36'(empty_exp(8)));
    end
    bw(4);
    chk(36'(al_empty), 36'(empty_exp(11)));
    i_frmc_port_host.b_op(6'b101000, 36'h0);
    apb(1'b0, frmc_pkg::STAT_OFS, 32'h0);
    chk(36'(rd[frmc_pkg::ST_RETX]), 36'h1);
    for (int i = 1; i < 4; i++) begin
      i_frmc_port_host.b_op(6'b100110, 36'h0);
      chk(b_dout, w[i]);
    end
    bw(3);
    chk(36'(al_empty), 36'(empty_exp(8)));
    i_frmc_port_host.b_op(6'b111000, 36'h0);
    chk(36'(o_rdy), 36'h1);
    chk(b_dout, w[0]);
    bw(2);
    chk(36'(al_empty), 36'(empty_exp(11)));
    i_frmc_port_host.b_op(6'b001000, 36'h0);
    for (int i = 1; i < 12; i++) begin
      i_frmc_port_host.b_op(6'b000110, 36'h0);
      chk(b_dout, w[i]);
    end
    i_frmc_port_host.b_op(6'b000110, 36'h0);
    bw(4);
    chk({o_rdy, al_empty, i_rdy, al_full}, 36'h3);
    apb(1'b1, frmc_pkg::CTRL_OFS, 32'h3);
    apb(1'b1, frmc_pkg::CTRL_OFS, 32'h7);
    bw(3);
    apb(1'b0, frmc_pkg::STAT_OFS, 32'h0);
    chk({rd[frmc_pkg::ST_PROG], i_rdy}, 36'h2);
    i_frmc_port_host.a_op(4'b0110, 36'h3);
    bw(1);
    i_frmc_port_host.a_op(4'b0110, 36'h5);
    bw(4);
    chk({o_rdy, i_rdy}, 36'h1);
    apb(1'b0, frmc_pkg::OFFS_OFS, 32'h0);
    chk({4'h0, rd}, 36'h000050003);
    end_of_test();
  end
endmodule : fifo_retransmit_mailbox_ctrl_test
`default_nettype wire
